/* common/asrc_map.svh */
// constants for the async static memory host controller
`ifndef ASRC_MAP_SVH
`define ASRC_MAP_SVH
`define ASRC_CLK_PERIOD_NS   100
`define ASRC_POWER_UP_US     100
`define ASRC_POWER_UP_CYC    `ASRC_CYC_OF(`ASRC_POWER_UP_US * 1000)
`define ASRC_WR_CYCLE_NS     8
`define ASRC_WR_PULSE_NS     6
`define ASRC_RD_CYCLE_NS     8
`define ASRC_ACCESS_NS       8
`define ASRC_OE_HIZ_NS       4
`define ASRC_CYC_OF(ns)      (((ns) + `ASRC_CLK_PERIOD_NS - 1) / `ASRC_CLK_PERIOD_NS)
`define ASRC_WR_PULSE_CYC    `ASRC_CYC_OF(`ASRC_WR_PULSE_NS)
`define ASRC_RD_WAIT_CYC     `ASRC_CYC_OF(`ASRC_ACCESS_NS)
`define ASRC_TURN_CYC        `ASRC_CYC_OF(`ASRC_OE_HIZ_NS)
`define ASRC_ADDR_W          18
`define ASRC_DATA_W          16
`define ASRC_LANE_W          8
`define ASRC_CNT_W           11
`endif

/* common/asrc_pkg.sv */
// types for the async static memory host controller
package asrc_pkg;
  typedef enum logic [2:0] {
    ASRC_ST_POWER = 3'h0,
    ASRC_ST_IDLE  = 3'h1,
    ASRC_ST_WSET  = 3'h2,
    ASRC_ST_WPUL  = 3'h3,
    ASRC_ST_WEND  = 3'h4,
    ASRC_ST_RACC  = 3'h5,
    ASRC_ST_RCAP  = 3'h6,
    ASRC_ST_TURN  = 3'h7
  } asrc_state_e;
endpackage

/* common/asrc_tmr_if.sv */
// timer hand-shake between sequencer and timer
`timescale 1ns/100ps
`include "asrc_map.svh"
interface asrc_tmr_if;
  logic                   load;
  logic [`ASRC_CNT_W-1:0] value;
  logic                   done;
  modport master (output load, output value, input done);
  modport timer  (input load, input value, output done);
endinterface

/* verilog/asrc_timer.sv */
// down counter that times the power-up wait, write pulse, read access and turnaround
`timescale 1ns/100ps
`include "asrc_map.svh"
module asrc_timer (
  input  wire logic sys_clk_i,
  input  wire logic reset_n_i,
  asrc_tmr_if.timer tmr
);
  logic [`ASRC_CNT_W-1:0] cnt_reg;
  logic [`ASRC_CNT_W-1:0] cnt_next;

  always_comb begin
    cnt_next = cnt_reg;
    if (tmr.load) begin
      cnt_next = tmr.value;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - `ASRC_CNT_W'(1);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // done looks only at the count, so no path runs from load back to done
  assign tmr.done = (cnt_reg == '0);
endmodule // asrc_timer

/* verilog/asrc_host.sv */
// host controller driving a 256K x 16 asynchronous static memory
`timescale 1ns/100ps
`include "asrc_map.svh"
module asrc_host (
  input  wire logic                    sys_clk_i,
  input  wire logic                    reset_n_i,
  input  wire logic                    req_valid_i,
  input  wire logic                    req_write_i,
  input  wire logic [`ASRC_ADDR_W-1:0] req_addr_i,
  input  wire logic [`ASRC_DATA_W-1:0] req_wdata_i,
  input  wire logic [1:0]              req_lane_en_i,
  output logic                         req_ready_o,
  output logic                         rsp_valid_o,
  output logic [`ASRC_DATA_W-1:0]      rsp_rdata_o,
  output logic [`ASRC_ADDR_W-1:0]      word_address_lines_o,
  output logic                         chip_select_n_o,
  output logic                         output_enable_n_o,
  output logic                         write_strobe_n_o,
  output logic                         lower_byte_lane_n_o,
  output logic                         upper_byte_lane_n_o,
  input  wire logic [`ASRC_DATA_W-1:0] shared_data_lines_i,
  output logic [`ASRC_DATA_W-1:0]      shared_data_lines_o,
  output logic                         shared_data_lines_oe_o
);
  //----------------------------------------
  // state
  //----------------------------------------
  asrc_pkg::asrc_state_e           state_reg, state_next;
  logic [`ASRC_ADDR_W-1:0]         addr_reg, addr_next;
  logic [`ASRC_DATA_W-1:0]         wdata_reg, wdata_next;
  logic [`ASRC_DATA_W-1:0]         rdata_reg, rdata_next;
  logic                            ce_n_reg, ce_n_next;
  logic                            oe_n_reg, oe_n_next;
  logic                            we_n_reg, we_n_next;
  logic [1:0]                      lane_n_reg, lane_n_next;
  logic                            drv_reg, drv_next;
  logic                            ready_reg, ready_next;
  logic                            rsp_reg, rsp_next;
  logic                            pwr_load_reg;

  asrc_tmr_if tmr ();

  asrc_timer u_timer (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .tmr       (tmr)
  );

  function automatic logic [`ASRC_CNT_W-1:0] cyc(input int n);
    cyc = (n < 1) ? `ASRC_CNT_W'(1) : `ASRC_CNT_W'(n);
  endfunction

  //----------------------------------------
  // sequencer
  //----------------------------------------
  always_comb begin
    state_next  = state_reg;
    addr_next   = addr_reg;
    wdata_next  = wdata_reg;
    rdata_next  = rdata_reg;
    ce_n_next   = ce_n_reg;
    oe_n_next   = oe_n_reg;
    we_n_next   = we_n_reg;
    lane_n_next = lane_n_reg;
    drv_next    = drv_reg;
    ready_next  = 1'b0;
    rsp_next    = 1'b0;
    tmr.load    = 1'b0;
    tmr.value   = '0;
    case (state_reg)
      asrc_pkg::ASRC_ST_POWER: begin
        if (pwr_load_reg) begin
          tmr.load  = 1'b1;
          tmr.value = cyc(`ASRC_POWER_UP_CYC);
        end else if (tmr.done) begin
          state_next = asrc_pkg::ASRC_ST_IDLE;
          ready_next = 1'b1;
        end
      end
      asrc_pkg::ASRC_ST_IDLE: begin
        ready_next = 1'b1;
        if (req_valid_i && ready_reg && (req_lane_en_i != 2'h0)) begin
          ready_next  = 1'b0;
          addr_next   = req_addr_i;
          wdata_next  = req_wdata_i;
          lane_n_next = ~req_lane_en_i;
          if (req_write_i) begin
            drv_next   = 1'b1;
            state_next = asrc_pkg::ASRC_ST_WSET;
          end else begin
            ce_n_next  = 1'b0;
            oe_n_next  = 1'b0;
            tmr.load   = 1'b1;
            tmr.value  = cyc(`ASRC_RD_WAIT_CYC);
            state_next = asrc_pkg::ASRC_ST_RACC;
          end
        end
      end
      asrc_pkg::ASRC_ST_WSET: begin
        ce_n_next  = 1'b0;
        we_n_next  = 1'b0;
        tmr.load   = 1'b1;
        tmr.value  = cyc(`ASRC_WR_PULSE_CYC);
        state_next = asrc_pkg::ASRC_ST_WPUL;
      end
      asrc_pkg::ASRC_ST_WPUL: begin
        if (tmr.done) begin
          we_n_next  = 1'b1;
          state_next = asrc_pkg::ASRC_ST_WEND;
        end
      end
      asrc_pkg::ASRC_ST_WEND: begin
        ce_n_next   = 1'b1;
        lane_n_next = 2'h3;
        drv_next    = 1'b0;
        state_next  = asrc_pkg::ASRC_ST_IDLE;
        rsp_next    = 1'b1;
        ready_next  = 1'b0;
      end
      asrc_pkg::ASRC_ST_RACC: begin
        if (tmr.done) begin
          state_next = asrc_pkg::ASRC_ST_RCAP;
        end
      end
      asrc_pkg::ASRC_ST_RCAP: begin
        rdata_next  = shared_data_lines_i & {{8{!lane_n_reg[1]}}, {8{!lane_n_reg[0]}}};
        ce_n_next   = 1'b1;
        oe_n_next   = 1'b1;
        lane_n_next = 2'h3;
        rsp_next    = 1'b1;
        tmr.load    = 1'b1;
        tmr.value   = cyc(`ASRC_TURN_CYC);
        state_next  = asrc_pkg::ASRC_ST_TURN;
      end
      asrc_pkg::ASRC_ST_TURN: begin
        if (tmr.done) begin
          state_next = asrc_pkg::ASRC_ST_IDLE;
          ready_next = 1'b1;
        end
      end
      default: begin
        state_next = asrc_pkg::ASRC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      state_reg  <= asrc_pkg::ASRC_ST_POWER;
      addr_reg   <= '0;
      wdata_reg  <= '0;
      rdata_reg  <= '0;
      ce_n_reg   <= 1'b1;
      oe_n_reg   <= 1'b1;
      we_n_reg   <= 1'b1;
      lane_n_reg <= 2'h3;
      drv_reg    <= 1'b0;
      ready_reg  <= 1'b0;
      rsp_reg    <= 1'b0;
    end else begin
      state_reg  <= state_next;
      addr_reg   <= addr_next;
      wdata_reg  <= wdata_next;
      rdata_reg  <= rdata_next;
      ce_n_reg   <= ce_n_next;
      oe_n_reg   <= oe_n_next;
      we_n_reg   <= we_n_next;
      lane_n_reg <= lane_n_next;
      drv_reg    <= drv_next;
      ready_reg  <= ready_next;
      rsp_reg    <= rsp_next;
    end
  end

  // power-up wait loads the timer once, on the first cycle out of reset
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      pwr_load_reg <= 1'b1;
    end else begin
      pwr_load_reg <= 1'b0;
    end
  end

  //----------------------------------------
  // outputs
  //----------------------------------------
  assign req_ready_o            = ready_reg;
  assign rsp_valid_o            = rsp_reg;
  assign rsp_rdata_o            = rdata_reg;
  assign word_address_lines_o   = addr_reg;
  assign chip_select_n_o        = ce_n_reg;
  assign output_enable_n_o      = oe_n_reg;
  assign write_strobe_n_o       = we_n_reg;
  assign lower_byte_lane_n_o    = lane_n_reg[0];
  assign upper_byte_lane_n_o    = lane_n_reg[1];
  assign shared_data_lines_o    = wdata_reg;
  assign shared_data_lines_oe_o = drv_reg;

  //----------------------------------------
  // assertions
  //----------------------------------------
  AST_NO_CONTENTION: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    !(drv_reg && !oe_n_reg)) else $error("host and memory drive together");
  AST_WE_HIGH_IN_READ: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    !oe_n_reg |-> we_n_reg) else $error("strobe low during read");
  AST_WE_INSIDE_CE: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    !we_n_reg |-> (!ce_n_reg && drv_reg && lane_n_reg != 2'h3)) else $error("bad write start");
  AST_DATA_HOLD: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    $rose(we_n_reg) |-> drv_reg && $stable(wdata_reg) && $stable(addr_reg))
    else $error("data moved at write end");
  AST_ADDR_BEFORE_CE: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    $fell(ce_n_reg) |-> $stable(addr_reg) || state_reg == asrc_pkg::ASRC_ST_RACC)
    else $error("address not set at select");
  AST_WRITE_PULSE: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    $fell(we_n_reg) |-> !we_n_reg [*2]) else $error("write pulse too short");
  AST_READ_WAIT: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    $fell(oe_n_reg) |-> !oe_n_reg [*2]) else $error("read sampled too early");
  AST_POWER_WAIT: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    state_reg == asrc_pkg::ASRC_ST_POWER |-> ce_n_reg) else $error("access during power wait");
  AST_END_DESELECT: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    $rose(we_n_reg) |=> ce_n_reg && lane_n_reg == 2'h3) else $error("write not closed");

  COV_WRITE: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i) $fell(we_n_reg));
  COV_READ: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i) $fell(oe_n_reg));
  COV_LOW_ONLY: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    !ce_n_reg && lane_n_reg == 2'h2);
  COV_UP_ONLY: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    !ce_n_reg && lane_n_reg == 2'h1);
endmodule // asrc_host

/* dv/asrc_mem_model.sv */
// behavioural model of the 256K x 16 static memory on the far side
`timescale 1ns/100ps
module asrc_mem_model (
  input  wire logic [17:0] addr_i,
  input  wire logic        cs_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic        lo_n_i,
  input  wire logic        hi_n_i,
  input  wire logic [15:0] bus_i,
  output logic      [15:0] data_o,
  output logic      [1:0]  drive_o
);
  logic [15:0] mem [logic [17:0]];
  logic [15:0] word;
  logic [1:0]  rd_lane;
  logic        wr_act;
  initial data_o = 16'h0000;
  initial drive_o = 2'h0;
  always @(addr_i, cs_n_i, oe_n_i, we_n_i, lo_n_i, hi_n_i, bus_i) begin
    word = mem.exists(addr_i) ? mem[addr_i] : ~addr_i[15:0];
    wr_act = !cs_n_i && !we_n_i && !(lo_n_i && hi_n_i);
    if (wr_act) begin
      mem[addr_i] = {hi_n_i ? word[15:8] : bus_i[15:8],
                     lo_n_i ? word[7:0] : bus_i[7:0]};
      word = mem[addr_i];
    end
    rd_lane = (!cs_n_i && !oe_n_i && we_n_i) ? {!hi_n_i, !lo_n_i} : 2'h0;
    // released lanes show the inverse so stale data never passes
    drive_o <= #4 rd_lane;
    data_o  <= #5 {rd_lane[1] ? word[15:8] : ~word[15:8],
                   rd_lane[0] ? word[7:0] : ~word[7:0]};
  end
endmodule // asrc_mem_model

/* dv/asrc_host_tb.sv */
// self-checking bench for the static memory host controller
`timescale 1ns/100ps
`include "asrc_map.svh"
module asrc_host_tb;
  logic                    clk = 1'b0;
  logic                    rst_n = 1'b0;
  logic                    valid = 1'b0;
  logic                    write = 1'b0;
  logic [`ASRC_ADDR_W-1:0] addr = 18'h00000;
  logic [`ASRC_DATA_W-1:0] wdata = 16'h0000;
  logic [1:0]              lanes = 2'h0;
  logic                    ready, rsp, cs_n, oe_n, we_n, lo_n, hi_n, host_oe;
  logic [`ASRC_DATA_W-1:0] rdata, host_d, mem_d, bus;
  logic [`ASRC_ADDR_W-1:0] mem_a;
  logic [1:0]              mem_drv;
  logic                    seen_ready = 1'b0;
  int                      errors = 0;
  int                      num_checks = 0;
  int                      cycles = 0;
  always #50 clk = ~clk;
  assign bus = host_oe ? host_d : mem_d;
  asrc_host i_asrc_host (.sys_clk_i(clk), .reset_n_i(rst_n), .req_valid_i(valid),
    .req_write_i(write), .req_addr_i(addr), .req_wdata_i(wdata), .req_lane_en_i(lanes),
    .req_ready_o(ready), .rsp_valid_o(rsp), .rsp_rdata_o(rdata),
    .word_address_lines_o(mem_a), .chip_select_n_o(cs_n), .output_enable_n_o(oe_n),
    .write_strobe_n_o(we_n), .lower_byte_lane_n_o(lo_n), .upper_byte_lane_n_o(hi_n),
    .shared_data_lines_i(bus), .shared_data_lines_o(host_d),
    .shared_data_lines_oe_o(host_oe));
  asrc_mem_model i_asrc_mem_model (.addr_i(mem_a), .cs_n_i(cs_n), .oe_n_i(oe_n),
    .we_n_i(we_n), .lo_n_i(lo_n), .hi_n_i(hi_n), .bus_i(bus), .data_o(mem_d),
    .drive_o(mem_drv));
  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(negedge clk) begin
    cycles++;
    if (ready === 1'b1 && !seen_ready) chk(cycles >= `ASRC_POWER_UP_CYC + 2, 1'b1);
    if (ready === 1'b1) seen_ready = 1'b1;
    if (!seen_ready) chk(cs_n, 1'b1);
    chk(host_oe & |mem_drv, 1'b0);
    if (oe_n === 1'b0) chk(we_n, 1'b1);
    if (cycles == 4000) begin
      errors++;
      tally_and_finish();
    end
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic req(input logic w, input logic [17:0] a, input logic [15:0] d,
                     input logic [1:0] ln, input logic [15:0] exp);
    int n;
    @(posedge clk);
    valid <= 1'b1;
    write <= w;
    addr  <= a;
    wdata <= d;
    lanes <= ln;
    n = 0;
    @(negedge clk);
    while (ready !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    valid <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      @(negedge clk);
    end while (rsp !== 1'b1 && n < 20);
    chk(n, w ? 4 : 3);
    if (!w) chk(rdata, exp);
    n = 0;
    while (ready !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk(n, w ? 1 : 2);
  endtask
  task automatic refused;
    @(posedge clk);
    valid <= 1'b1;
    lanes <= 2'h0;
    repeat (6) begin
      @(negedge clk);
      chk(rsp, 1'b0);
      chk(cs_n, 1'b1);
    end
    @(posedge clk);
    valid <= 1'b0;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    req(1'b1, 18'h00000, 16'hA5C3, 2'h3, 16'h0000);
    req(1'b1, 18'h00000, 16'h5A3C, 2'h1, 16'h0000);
    req(1'b1, 18'h00000, 16'hFF00, 2'h2, 16'h0000);
    req(1'b0, 18'h00000, 16'h0000, 2'h3, 16'hFF3C);
    req(1'b0, 18'h00000, 16'h0000, 2'h1, 16'h003C);
    req(1'b0, 18'h00000, 16'h0000, 2'h2, 16'hFF00);
    req(1'b1, 18'h3FFFF, 16'h1234, 2'h3, 16'h0000);
    req(1'b0, 18'h3FFFF, 16'h0000, 2'h3, 16'h1234);
    req(1'b0, 18'h00001, 16'h0000, 2'h3, 16'hFFFE);
    refused();
    tally_and_finish();
  end
endmodule // asrc_host_tb
